// file: rtl/fpt_pkg.sv
package fpt_pkg;
  // System clock rate in hertz.
  localparam int CLK_HZ = 200_000_000;
  // Nominal fan PWM repetition rate in hertz.
  localparam int PWM_HZ = 18;
  // Duty steps in one PWM period, one per percent.
  localparam int PWM_STEPS = 100;
  // Cycles per duty step.
  localparam int PWM_STEP_CYC = CLK_HZ / PWM_HZ / PWM_STEPS;
  // Measurement window in milliseconds and in cycles.
  localparam int WIN_MS = 125;
  localparam int WIN_CYC = CLK_HZ / 1000 * WIN_MS;
  // Start-up stagger delay in milliseconds and in cycles.
  localparam int STAG_MS = 500;
  localparam int STAG_CYC = CLK_HZ / 1000 * STAG_MS;
  // Number of fan channels.
  localparam int NFAN = 4;
  // Full power level.
  localparam logic [6:0] LVL_FULL = 7'h64;
  // Register byte offsets.
  localparam logic [7:0] OFS_POWER = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_TMO = 8'h08;
  localparam logic [7:0] OFS_GLI = 8'h0C;
  localparam logic [7:0] OFS_SPEED = 8'h10;
  localparam logic [7:0] OFS_STS = 8'h14;
  localparam logic [7:0] OFS_MSK = 8'h18;
  localparam logic [7:0] OFS_STATE = 8'h1C;
  // Values after reset.
  localparam logic [31:0] TMO_RST = 32'h1010_1010;
  localparam logic [31:0] GLI_RST = 32'h0101_0101;
  // Cycle after reset release at which boot levels are loaded.
  localparam logic [1:0] BOOT_WAIT = 2'h2;
endpackage : fpt_pkg

// file: rtl/fpt_fan_ctrl.sv
`timescale 1ns/1ps
// Contract
// - four fan channels, output and tach each
// - duty cycle follows power level 0..100
// - PWM period is eighteen hertz
// - count tach edges over 125 ms
// - fans measured in rotation, 125 ms each
// - reporting fan forced on at window start
// - hold on until glitch delay, two edges
// - stretched pulse ends within 125 ms
// - fail-safe forces full power on timeout
// - boot level is full or saved
// - fans started one per 500 ms; a zero-level fan costs no delay
module fpt_fan_ctrl #(
  parameter int STEP_CYC = fpt_pkg::PWM_STEP_CYC,
  parameter int WIN_CYC = fpt_pkg::WIN_CYC,
  parameter int STAG_CYC = fpt_pkg::STAG_CYC
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // APB register port.
  input wire logic apb_psel_i,
  input wire logic apb_penable_i,
  input wire logic apb_pwrite_i,
  input wire logic [7:0] apb_paddr_i,
  input wire logic [31:0] apb_pwdata_i,
  output logic [31:0] apb_prdata_o,
  output logic apb_pready_o,
  output logic apb_pslverr_o,
  // Fan switches and tachometers.
  input wire logic [fpt_pkg::NFAN-1:0] fan_tach_i,
  output logic [fpt_pkg::NFAN-1:0] fan_on_o,
  // Boot straps.
  input wire logic boot_saved_i,
  input wire logic [27:0] boot_level_i,
  // Interrupt.
  output logic irq_o
);
  import fpt_pkg::*;

  // Limits a written level to full power.
  function automatic logic [6:0] clamp_lvl(input logic [7:0] v);
    clamp_lvl = (v > {1'b0, LVL_FULL}) ? LVL_FULL : v[6:0];
  endfunction : clamp_lvl

  // Synchroniser stages for pins.
  logic [3:0] ts1_reg, ts2_reg, ts3_reg;
  logic [28:0] bs1_reg, bs2_reg;
  // Register file: levels, enables, timeouts, glitch delays, status, mask and read data.
  logic [27:0] pow_reg, pow_next;
  logic [3:0] rep_reg, rep_next, fse_reg, fse_next;
  logic [31:0] tmo_reg, tmo_next, gli_reg, gli_next, prd_reg, prd_next;
  logic [7:0] sts_reg, sts_next, msk_reg, msk_next;
  logic err_reg, err_next;
  // PWM timebase.
  logic [26:0] pre_reg, pre_next;
  logic [6:0] step_reg, step_next;
  // Measurement.
  logic [26:0] win_reg, win_next;
  logic [1:0] slot_reg, slot_next;
  logic [7:0] edg_reg, edg_next, gl_reg, gl_next;
  logic [3:0] str_reg, str_next;
  logic [31:0] spd_reg, spd_next;
  // Fail-safe.
  logic [31:0] fsc_reg, fsc_next;
  logic [3:0] fs_reg, fs_next;
  // Start-up sequence.
  logic [1:0] ld_reg, ld_next;
  logic [2:0] seq_reg, seq_next;
  logic [26:0] stc_reg, stc_next;
  logic [3:0] on_reg, on_next, fan_reg, fan_next;
  // Shared strobes.
  logic wr_w, setup_w, pw_upd, tick_w, win_end_w, ld_w, run_w;
  logic [3:0] done_w, trip_w;
  logic [7:0] clr_w;
  logic [6:0] lvl_w [NFAN];
  logic [3:0] edge_w;

  assign setup_w = apb_psel_i & ~apb_penable_i;
  assign wr_w = apb_psel_i & apb_penable_i & apb_pwrite_i;
  assign tick_w = pre_reg == 27'(STEP_CYC - 1);
  assign win_end_w = win_reg == 27'(WIN_CYC - 1);
  assign ld_w = ld_reg == BOOT_WAIT;
  assign run_w = (ld_reg == 2'h3) && !seq_reg[2];
  assign edge_w = ts2_reg & ~ts3_reg;
  assign apb_pready_o = 1'b1;
  assign apb_prdata_o = prd_reg;
  assign apb_pslverr_o = err_reg;
  assign fan_on_o = fan_reg;
  assign irq_o = |(sts_reg & msk_reg);

  // Effective level per fan, full power while the fail-safe holds.
  always_comb begin
    for (int i = 0; i < NFAN; i++) begin
      lvl_w[i] = fs_reg[i] ? LVL_FULL : pow_reg[7*i +: 7];
    end
  end

  // Pin synchronisers; logic reads the second stage, and the third stage for tach edge detection.
  always_ff @(posedge core_clk_i) begin
    ts1_reg <= fan_tach_i;
    ts2_reg <= ts1_reg;
    ts3_reg <= ts2_reg;
    bs1_reg <= {boot_saved_i, boot_level_i};
    bs2_reg <= bs1_reg;
  end

  // Register writes, boot load, status and read data.
  always_comb begin
    {pow_next, rep_next, fse_next, tmo_next} = {pow_reg, rep_reg, fse_reg, tmo_reg};
    {gli_next, msk_next, prd_next, err_next} = {gli_reg, msk_reg, prd_reg, err_reg};
    clr_w = 8'h00;
    pw_upd = 1'b0;
    // Boot level is loaded once after reset release.
    if (ld_w) begin
      for (int i = 0; i < NFAN; i++) begin
        pow_next[7*i +: 7] = bs2_reg[28] ? clamp_lvl({1'b0, bs2_reg[7*i +: 7]}) : LVL_FULL;
      end
    end
    // Writes take effect in the access phase.
    if (wr_w) begin
      case (apb_paddr_i)
        OFS_POWER: begin
          for (int i = 0; i < NFAN; i++) begin
            pow_next[7*i +: 7] = clamp_lvl(apb_pwdata_i[8*i +: 8]);
          end
          pw_upd = 1'b1;
        end
        OFS_CFG: begin
          rep_next = apb_pwdata_i[3:0];
          fse_next = apb_pwdata_i[11:8];
        end
        OFS_TMO: tmo_next = apb_pwdata_i;
        OFS_GLI: gli_next = apb_pwdata_i;
        OFS_STS: clr_w = apb_pwdata_i[7:0];
        OFS_MSK: msk_next = apb_pwdata_i[7:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    sts_next = (sts_reg & ~clr_w) | {trip_w, done_w};
    // Read data is prepared in the setup phase.
    if (setup_w) begin
      err_next = 1'b0;
      prd_next = 32'h0000_0000;
      case (apb_paddr_i)
        OFS_POWER: begin
          for (int i = 0; i < NFAN; i++) begin
            prd_next[8*i +: 8] = {1'b0, pow_reg[7*i +: 7]};
          end
        end
        OFS_CFG: prd_next = {20'h0_0000, fse_reg, 4'h0, rep_reg};
        OFS_TMO: prd_next = tmo_reg;
        OFS_GLI: prd_next = gli_reg;
        OFS_SPEED: prd_next = spd_reg;
        OFS_STS: prd_next = {24'h00_0000, sts_reg};
        OFS_MSK: prd_next = {24'h00_0000, msk_reg};
        OFS_STATE: prd_next = {24'h00_0000, on_reg, fs_reg};
        default: err_next = 1'b1;
      endcase
    end
  end

  // PWM timebase: STEP_CYC cycles per step, 100 steps per period.
  always_comb begin
    pre_next = tick_w ? 27'h000_0000 : pre_reg + 27'h000_0001;
    step_next = step_reg;
    if (tick_w) begin
      step_next = (step_reg == 7'(PWM_STEPS - 1)) ? 7'h00 : step_reg + 7'h01;
    end
  end

  // Measurement window rotating over the fans.
  always_comb begin
    win_next = win_end_w ? 27'h000_0000 : win_reg + 27'h000_0001;
    slot_next = slot_reg;
    edg_next = edg_reg;
    gl_next = gl_reg;
    str_next = str_reg;
    spd_next = spd_reg;
    done_w = 4'h0;
    if (win_end_w) begin
      // Store the edge count and move to the next fan.
      spd_next[8*slot_reg +: 8] = edg_reg;
      done_w[slot_reg] = rep_reg[slot_reg];
      slot_next = slot_reg + 2'h1;
      edg_next = 8'h00;
      gl_next = 8'h00;
      // Any stretch ends with its window.
      str_next = 4'h0;
      str_next[slot_next] = rep_reg[slot_next];
    end else begin
      // Counters saturate rather than wrap.
      if (edge_w[slot_reg] && edg_reg != 8'hFF) begin
        edg_next = edg_reg + 8'h01;
      end
      if (tick_w && gl_reg != 8'hFF) begin
        gl_next = gl_reg + 8'h01;
      end
      // Release the stretch once filtered and two edges seen.
      if (edg_reg >= 8'h02 && gl_reg >= gli_reg[8*slot_reg +: 8]) begin
        str_next[slot_reg] = 1'b0;
      end
    end
  end

  // Fail-safe timers, counted in measurement windows.
  always_comb begin
    fsc_next = fsc_reg;
    fs_next = fs_reg;
    trip_w = 4'h0;
    if (pw_upd) begin
      fsc_next = 32'h0000_0000;
      fs_next = 4'h0;
    end else begin
      for (int i = 0; i < NFAN; i++) begin
        if (!fse_reg[i]) begin
          fsc_next[8*i +: 8] = 8'h00;
        end else if (win_end_w && !fs_reg[i]) begin
          if (fsc_reg[8*i +: 8] == tmo_reg[8*i +: 8]) begin
            fs_next[i] = 1'b1;
            trip_w[i] = 1'b1;
          end else begin
            fsc_next[8*i +: 8] = fsc_reg[8*i +: 8] + 8'h01;
          end
        end
      end
    end
  end

  // Start-up sequence and the switch outputs.
  always_comb begin
    ld_next = (ld_reg == 2'h3) ? ld_reg : ld_reg + 2'h1;
    seq_next = seq_reg;
    stc_next = stc_reg;
    on_next = on_reg;
    if (run_w) begin
      if (stc_reg == 27'h000_0000) begin
        on_next[seq_reg[1:0]] = 1'b1;
        // Only a fan with a nonzero level costs a delay.
        if (lvl_w[seq_reg[1:0]] != 7'h00) begin
          stc_next = 27'h000_0001;
        end else begin
          seq_next = seq_reg + 3'h1;
        end
      end else if (stc_reg == 27'(STAG_CYC - 1)) begin
        stc_next = 27'h000_0000;
        seq_next = seq_reg + 3'h1;
      end else begin
        stc_next = stc_reg + 27'h000_0001;
      end
    end
    for (int i = 0; i < NFAN; i++) begin
      fan_next[i] = on_reg[i] & (str_reg[i] | (step_reg < lvl_w[i]));
    end
  end

  // State registers with synchronous reset.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      // Everything clears except the timeouts and glitch delays.
      {pow_reg, rep_reg, fse_reg, sts_reg, msk_reg, prd_reg, err_reg} <= '0;
      tmo_reg <= TMO_RST;
      gli_reg <= GLI_RST;
      {pre_reg, step_reg, win_reg, slot_reg, edg_reg, gl_reg, str_reg, spd_reg} <= '0;
      {fsc_reg, fs_reg, ld_reg, seq_reg, stc_reg, on_reg, fan_reg} <= '0;
    end else begin
      {pow_reg, rep_reg, fse_reg} <= {pow_next, rep_next, fse_next};
      {tmo_reg, gli_reg, sts_reg} <= {tmo_next, gli_next, sts_next};
      {msk_reg, prd_reg, err_reg} <= {msk_next, prd_next, err_next};
      {pre_reg, step_reg, win_reg} <= {pre_next, step_next, win_next};
      {slot_reg, edg_reg, gl_reg} <= {slot_next, edg_next, gl_next};
      {str_reg, spd_reg, fsc_reg} <= {str_next, spd_next, fsc_next};
      {fs_reg, ld_reg, seq_reg} <= {fs_next, ld_next, seq_next};
      {stc_reg, on_reg, fan_reg} <= {stc_next, on_next, fan_next};
    end
  end

  // Checks on the behaviour above.
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_zero_off;
    pow_reg[6:0] == 7'h00 && !fs_reg[0] && !str_reg[0] |=> !fan_on_o[0];
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("fan 0 on at zero level");
  property p_step_wrap;
    tick_w && step_reg == 7'h63 |=> step_reg == 7'h00;
  endproperty
  a_step_wrap: assert property (p_step_wrap) else $error("duty step did not wrap");
  property p_win_store;
    win_end_w && slot_reg == 2'h0 |=> spd_reg[7:0] == $past(edg_reg);
  endproperty
  a_win_store: assert property (p_win_store) else $error("speed not stored");
  property p_slot_step;
    win_end_w |=> slot_reg == $past(slot_reg) + 2'h1 && edg_reg == 8'h00;
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot did not rotate");
  property p_str_start;
    win_end_w && rep_reg[slot_reg + 2'h1] |=> str_reg[slot_reg];
  endproperty
  a_str_start: assert property (p_str_start) else $error("stretch not started");
  property p_str_hold;
    str_reg != 4'h0 && edg_reg < 8'h02 && !win_end_w |=> $stable(str_reg);
  endproperty
  a_str_hold: assert property (p_str_hold) else $error("stretch ended early");
  property p_str_limit;
    win_end_w |=> (str_reg & ~(4'h1 << slot_reg)) == 4'h0;
  endproperty
  a_str_limit: assert property (p_str_limit) else $error("stretch outlived window");
  // Every started fan under fail-safe force conducts in the next cycle.
  property p_fs_full;
    (fs_reg & on_reg) != 4'h0 |=> (fan_on_o & $past(fs_reg & on_reg)) == $past(fs_reg & on_reg);
  endproperty
  a_fs_full: assert property (p_fs_full) else $error("fail-safe fan not on");
  property p_boot_full;
    ld_w && !bs2_reg[28] |=> pow_reg == {4{LVL_FULL}};
  endproperty
  a_boot_full: assert property (p_boot_full) else $error("boot level not full");
  property p_stagger;
    run_w && stc_reg != 27'h000_0000 && stc_reg != 27'(STAG_CYC - 1) |=> $stable(seq_reg);
  endproperty
  a_stagger: assert property (p_stagger) else $error("fan started too soon");
  property p_fs_restart;
    pw_upd |=> fs_reg == 4'h0 && fsc_reg == 32'h0000_0000;
  endproperty
  a_fs_restart: assert property (p_fs_restart) else $error("timer not restarted");

endmodule : fpt_fan_ctrl

// file: sim/fpt_fan_model.sv
`timescale 1ns/1ps
// Behavioural three-pin fan: the tach output toggles every HALF cycles while
// the ground switch conducts, and sits at its pull-up level while unpowered.
module fpt_fan_model #(
  parameter int HALF = 10
) (
  // Clock and power.
  input wire logic clk_i,
  input wire logic on_i,
  // Tachometer output.
  output logic tach_o
);
  int cnt_reg = 0; // Cycles since the last tach toggle.
  initial tach_o = 1'b1;
  // A stopped fan gives no edges, so the pull-up holds the line high.
  always @(posedge clk_i) begin
    if (!on_i) begin
      cnt_reg <= 0;
      tach_o <= 1'b1;
    end else if (cnt_reg == HALF - 1) begin
      cnt_reg <= 0;
      tach_o <= ~tach_o;
    end else begin
      cnt_reg <= cnt_reg + 1;
    end
  end
endmodule : fpt_fan_model

// file: sim/tb_fan_pwm_tach_monitor.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got %h expected %h", $time, (a), (e)); end end
// Bench for the fan controller with four behavioural fans.
module tb_fan_pwm_tach_monitor;
  import fpt_pkg::*;
  localparam int STEP = 4; // Short duty step.
  localparam int WIN = 200; // Short window.
  localparam int STAG = 50; // Short stagger.
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire [NFAN-1:0] tach; // Each bit is driven by its own fan model.
  logic [NFAN-1:0] fan_on;
  logic saved = 1'b0;
  logic [27:0] level = 28'h0;
  logic irq;
  logic [31:0] rd; // Last read data.
  logic err; // Last slave error.
  int num_errors = 0;
  int comparisons = 0;
  int on_cnt [NFAN]; // On-cycles per fan.

  // Clock of 5 ns period.
  always #2.5 clk = ~clk;

  fpt_fan_ctrl #(.STEP_CYC(STEP), .WIN_CYC(WIN), .STAG_CYC(STAG)) i_fpt_fan_ctrl (
    .core_clk_i(clk), .resetn_i(resetn), .apb_psel_i(psel), .apb_penable_i(penable),
    .apb_pwrite_i(pwrite), .apb_paddr_i(paddr), .apb_pwdata_i(pwdata),
    .apb_prdata_o(prdata), .apb_pready_o(pready), .apb_pslverr_o(pslverr),
    .fan_tach_i(tach), .fan_on_o(fan_on), .boot_saved_i(saved),
    .boot_level_i(level), .irq_o(irq));

  // One fan on each channel.
  for (genvar f = 0; f < NFAN; f++) begin : g_fan
    fpt_fan_model #(.HALF(10)) i_fpt_fan_model (.clk_i(clk), .on_i(fan_on[f]),
      .tach_o(tach[f]));
  end

  // One APB transfer; request held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reset with the given straps, which settle before release.
  task automatic do_reset(input logic s, input logic [27:0] l);
    resetn <= 1'b0;
    saved <= s;
    level <= l;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
  endtask : do_reset

  // Counts on-cycles of every fan over n cycles.
  task automatic count_on(input int n);
    on_cnt = '{default: 0};
    repeat (n) begin
      @(negedge clk);
      for (int f = 0; f < NFAN; f++) on_cnt[f] += int'(fan_on[f]);
    end
  endtask : count_on

  // Full-power boot, staggered start and register defaults.
  task automatic t_boot_full();
    do_reset(1'b0, 28'h0);
    repeat (30) @(negedge clk);
    `CHK(fan_on, 4'h1)
    repeat (50) @(negedge clk);
    `CHK(fan_on, 4'h3)
    repeat (50) @(negedge clk);
    `CHK(fan_on, 4'h7)
    repeat (50) @(negedge clk);
    `CHK(fan_on, 4'hF)
    apb(1'b0, OFS_POWER, 32'h0);
    `CHK(rd, 32'h6464_6464)
    apb(1'b0, OFS_TMO, 32'h0);
    `CHK(rd, TMO_RST)
    apb(1'b0, OFS_GLI, 32'h0);
    `CHK(rd, GLI_RST)
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h20, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("boot test done");
  endtask : t_boot_full

  // Duty cycle over two whole PWM periods.
  task automatic t_pwm();
    apb(1'b1, OFS_POWER, 32'h6400_1E32); // Levels 50, 30, 0 and 100
    count_on(400);
    count_on(800);
    `CHK(on_cnt[0], 50 * STEP * 2)
    `CHK(on_cnt[1], 30 * STEP * 2)
    `CHK(on_cnt[2], 0)
    `CHK(on_cnt[3], 800)
    $display("pwm test done");
  endtask : t_pwm

  // Speed results, done flags and the interrupt.
  task automatic t_speed();
    apb(1'b1, OFS_POWER, 32'h6464_6464);
    apb(1'b1, OFS_CFG, 32'h0000_000F);
    apb(1'b1, OFS_MSK, 32'h0);
    // Long enough that every fan gets one whole window at the new level.
    repeat (1100) @(negedge clk);
    apb(1'b0, OFS_SPEED, 32'h0);
    for (int f = 0; f < NFAN; f++) `CHK(rd[8*f+:8] inside {[9:11]}, 1'b1)
    apb(1'b0, OFS_STS, 32'h0);
    `CHK({rd[3:0], irq}, 5'h1E)
    apb(1'b1, OFS_MSK, 32'h1);
    // The mask lands at the access edge; look once it has settled.
    @(negedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, OFS_CFG, 32'h0);
    apb(1'b1, OFS_STS, 32'hFF);
    apb(1'b0, OFS_STS, 32'h0);
    `CHK({rd[3:0], irq}, 5'h00)
    $display("speed test done");
  endtask : t_speed

  // Zero-level fan is stretched on only until two tach edges.
  task automatic t_stretch();
    apb(1'b1, OFS_POWER, 32'h6464_6400);
    apb(1'b1, OFS_CFG, 32'h0000_0001);
    count_on(800);
    count_on(800);
    `CHK(on_cnt[0] inside {[20:60]}, 1'b1)
    apb(1'b1, OFS_CFG, 32'h0);
    $display("stretch test done");
  endtask : t_stretch

  // Fail-safe trip, and timer restart on a power write.
  task automatic t_failsafe();
    apb(1'b1, OFS_TMO, 32'h1010_0210);
    apb(1'b1, OFS_CFG, 32'h0000_0200);
    apb(1'b1, OFS_POWER, 32'h6464_1E64);
    repeat (150) @(negedge clk);
    apb(1'b1, OFS_POWER, 32'h6464_1E64);
    repeat (150) @(negedge clk);
    apb(1'b0, OFS_STATE, 32'h0);
    `CHK(rd[1], 1'b0)
    repeat (500) @(negedge clk);
    apb(1'b0, OFS_STATE, 32'h0);
    `CHK(rd[1], 1'b1)
    apb(1'b0, OFS_STS, 32'h0);
    `CHK(rd[5], 1'b1)
    count_on(400);
    `CHK(on_cnt[1], 400)
    apb(1'b1, OFS_POWER, 32'h6464_1E64);
    apb(1'b0, OFS_STATE, 32'h0);
    `CHK(rd[1], 1'b0)
    $display("failsafe test done");
  endtask : t_failsafe

  // Saved boot levels, clamping and zero-level skip in the stagger.
  task automatic t_boot_saved();
    do_reset(1'b1, {7'h78, 7'h00, 7'h2D, 7'h46});
    repeat (80) @(negedge clk);
    `CHK(fan_on[3], 1'b0)
    repeat (50) @(negedge clk);
    `CHK(fan_on[3], 1'b1)
    apb(1'b0, OFS_POWER, 32'h0);
    `CHK(rd, 32'h6400_2D46)
    $display("saved boot test done");
  endtask : t_boot_saved

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Counts: %0d errors, %0d comparisons", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // Main sequence.
  initial begin
    t_boot_full();
    t_pwm();
    t_speed();
    t_stretch();
    t_failsafe();
    t_boot_saved();
    stop_test();
  end

  // Watchdog, well past the expected run length.
  initial begin
    #(5 * 20000);
    num_errors++;
    stop_test();
  end
endmodule : tb_fan_pwm_tach_monitor
